/* sim/ext_instrument.sv */
// Far-side instrument model: sends arm edges, counts trigger edges
`timescale 1ns/10ps
`default_nettype none
module ext_instrument (
    // Request from the bench
    input  wire logic fire,
    // Arm pins
    input  wire logic port_out,
    output logic      port_in,
    // Observed trigger edges
    output int        edges
);
    // Off the core clock grid, as a foreign instrument would be
    initial begin
        port_in = 1'b0;
        forever begin
            @(fire);
            port_in <= #1.3 fire;
        end
    end

    // Only a rising edge counts as a received trigger
    initial begin
        edges = 0;
        forever begin
            @(posedge port_out);
            edges++;
        end
    end
endmodule
`default_nettype wire

/* sim/trigger_arming_test.sv */
// Self-checking bench for the arming crosslink
`timescale 1ns/10ps
`default_nettype none
module trigger_arming_test;
    import xarm_pkg::*;
    logic              core_clk   = 1'b0;
    logic              arst_n     = 1'b0;
    logic              psel       = 1'b0;
    logic              penable    = 1'b0;
    logic              pwrite     = 1'b0;
    logic [ADDR_W-1:0] paddr      = '0;
    logic [31:0]       pwdata     = '0;
    logic              run_start  = 1'b0;
    logic              run_stop   = 1'b0;
    logic [NUM_AN-1:0] trig_hit   = '0;
    logic              fire       = 1'b0;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              port_in;
    logic              port_out;
    logic [NUM_AN-1:0] seq_enable;
    logic [NUM_AN-1:0] arm_pulse;
    logic [LVL_W-1:0]  arm_level_a;
    logic [LVL_W-1:0]  arm_level_b;
    logic [NUM_AN-1:0] trig_found;
    logic [NUM_AN-1:0] time_tag_on;
    logic [NUM_AN-1:0] state_tag_on;
    logic              irq;
    int                edges;
    int                error_cnt  = 0;
    int                n_compared = 0;
    int                seed       = 57;
    int                mst [2];
    logic              pout_m     = 1'b0;
    logic [31:0]       rd;
    logic              err;
    logic [31:0]       cfg;
    logic [3:0]        lvl;
    logic [31:0]       exp_cfg;

    always #2 core_clk = ~core_clk;

    trigger_arming i_trigger_arming (
        .core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .run_start(run_start),
        .run_stop(run_stop), .trig_hit(trig_hit), .port_in(port_in),
        .port_out(port_out), .seq_enable(seq_enable), .arm_pulse(arm_pulse),
        .arm_level_a(arm_level_a), .arm_level_b(arm_level_b), .trig_found(trig_found),
        .time_tag_on(time_tag_on), .state_tag_on(state_tag_on), .irq(irq)
    );

    ext_instrument i_ext_instrument (
        .fire(fire), .port_out(port_out), .port_in(port_in), .edges(edges)
    );

    task automatic summarize;
        $display("mismatches %0d of %0d compared", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, msg, seen, exp);
        end
    endtask

    task automatic hang(input string msg);
        error_cnt++;
        $display("CHECK FAILED t=%0t wait ran out: %s", $time, msg);
        summarize();
    endtask

    // Master holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) hang("apb");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, "register read");
        chk(err, 1'b0, "slave error");
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic pulse_run(input logic stop);
        @(posedge core_clk);
        if (stop) run_stop <= 1'b1; else run_start <= 1'b1;
        @(posedge core_clk);
        run_stop <= 1'b0;
        run_start <= 1'b0;
    endtask

    task automatic hit(input logic [1:0] h);
        @(posedge core_clk);
        trig_hit <= h;
        @(posedge core_clk);
        trig_hit <= 2'b00;
    endtask

    function automatic logic sig(input int w);
        case (w)
            0: return arm_pulse[0];
            1: return trig_found[0];
            default: return trig_found[1];
        endcase
    endfunction

    // Pulse must come within the bound and last exactly one cycle
    task automatic wait_hi(input int w, input int bound);
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (sig(w) !== 1'b1 && n < bound);
        if (sig(w) !== 1'b1) hang("pulse");
        @(posedge core_clk);
        chk(sig(w), 1'b0, "pulse width");
    endtask

    function automatic logic [31:0] stat_exp(input logic warn);
        return {26'h0, warn, pout_m, 2'(mst[1]), 2'(mst[0])};
    endfunction

    initial begin
        mst = '{0, 0};
        repeat (4) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        chk(arm_level_a, 4'h0, "default level");
        chk(arm_level_b, 4'h0, "default level b");
        for (int i = 0; i < 6; i++) rdchk(8'(4 * i), 32'h0);
        apb(1'b0, 8'h18, 32'h0);
        chk({rd[30:0], err}, 32'h1, "unmapped read");
        apb(1'b1, OFS_INT_MASK, 32'hf);
        // Every tag code, the undefined one too; B gets a level unlike A's
        for (int t = 0; t < 4; t++) begin
            lvl = 4'($random(seed));
            cfg = {22'h0, 2'(t), lvl, 4'h2};
            exp_cfg = (t == 3) ? (cfg & 32'hffff_fcff) : cfg;
            apb(1'b1, OFS_CFG_A, cfg);
            apb(1'b1, OFS_CFG_B, {cfg[31:8], ~lvl, cfg[3:0]});
            cyc(2);
            chk(arm_level_a, lvl, "arm level");
            chk(arm_level_b, 4'(~lvl), "arm level b");
            chk({time_tag_on, state_tag_on}, {t == 1, t == 1, t == 2, t == 2}, "tag");
            rdchk(OFS_CFG_A, exp_cfg);
        end
        rdchk(OFS_INT_ST, 32'h8);
        chk(irq, 1'b1, "irq raised");
        apb(1'b1, OFS_INT_MASK, 32'h0);
        cyc(2);
        chk(irq, 1'b0, "irq masked");
        apb(1'b1, OFS_INT_MASK, 32'hf);
        apb(1'b1, OFS_INT_ST, 32'h8);
        cyc(2);
        chk(irq, 1'b0, "irq cleared");
        apb(1'b1, OFS_CFG_B, 32'h4);
        cyc(2);
        chk({time_tag_on[1], state_tag_on[1]}, 2'b10, "timing tags");
        // Port armed A, B without wait, arm out from B
        apb(1'b1, OFS_CFG_A, 32'h32);
        apb(1'b1, OFS_CTRL, 32'hf);
        fire <= 1'b1;
        cyc(6);
        pulse_run(1'b0);
        mst = '{1, 2};
        fire <= 1'b0;
        hit(2'b01);
        cyc(8);
        rdchk(OFS_STAT, stat_exp(1'b0));
        fire <= 1'b1;
        wait_hi(0, 12);
        mst[0] = 2;
        chk(seq_enable, 2'b11, "armed");
        hit(2'b01);
        wait_hi(1, 4);
        cyc(2);
        chk(port_out, 1'b0, "A does not drive out");
        hit(2'b10);
        wait_hi(2, 4);
        cyc(2);
        mst = '{3, 3};
        pout_m = 1'b1;
        chk(edges, 1, "one edge out");
        rdchk(OFS_STAT, stat_exp(1'b0));
        rdchk(OFS_INT_ST, 32'h7);
        apb(1'b1, OFS_INT_ST, 32'h7);
        // Run-start arming, B armed by A's trigger; single setup sends from A
        pulse_run(1'b1);
        apb(1'b1, OFS_CTRL, 32'h6);
        apb(1'b1, OFS_CFG_B, 32'h3);
        apb(1'b1, OFS_CFG_A, 32'h2);
        pulse_run(1'b0);
        mst = '{1, 1};
        pout_m = 1'b0;
        rdchk(OFS_STAT, stat_exp(1'b0));
        pulse_run(1'b0);
        wait_hi(0, 4);
        mst[0] = 2;
        rdchk(OFS_STAT, stat_exp(1'b0));
        hit(2'b01);
        wait_hi(1, 4);
        cyc(2);
        mst = '{3, 2};
        pout_m = 1'b1;
        rdchk(OFS_STAT, stat_exp(1'b0));
        chk(edges, 2, "second edge out");
        summarize();
    end
endmodule
`default_nettype wire

/* verilog/arm_edge_sync.sv */
// Two-flop synchroniser with rising-edge pulse for the arm input pin
`timescale 1ns/10ps
`default_nettype none
module arm_edge_sync (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic arst_n,
    // Pin and pulse
    input  wire logic pin_in,
    output logic      rise_pulse
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    // Only the second stage and its delayed copy are looked at
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    // Level held high gives one pulse only
    assign rise_pulse = sync_reg & ~last_reg;
endmodule
`default_nettype wire

/* verilog/trigger_arming.sv */
// Arming, cross-trigger routing and tag control for two analyzers
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Selected trigger drives rising edge on port out
// - Arm input reacts to rising edges only
// - Waiting analyzer ignores triggers until armed
// - Arm source is run start or input
// - Each analyzer picks its own arm supplier
// - Selector picks which analyzer drives arm out in dual setups; single setups use the first
// - Tag mode is off, time or states
// - Timing analyzer always time tags
// - Time tagging accepted, only raises warning
module trigger_arming
    import xarm_pkg::*;
(
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              arst_n,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Run control and analyzer triggers
    input  wire logic              run_start,
    input  wire logic              run_stop,
    input  wire logic [NUM_AN-1:0] trig_hit,
    // External arm pins
    input  wire logic              port_in,
    output logic                   port_out,
    // Sequencer side
    output logic [NUM_AN-1:0]      seq_enable,
    output logic [NUM_AN-1:0]      arm_pulse,
    output logic [LVL_W-1:0]       arm_level_a,
    output logic [LVL_W-1:0]       arm_level_b,
    output logic [NUM_AN-1:0]      trig_found,
    output logic [NUM_AN-1:0]      time_tag_on,
    output logic [NUM_AN-1:0]      state_tag_on,
    // Interrupt
    output logic                   irq
);
    logic [CTRL_W-1:0] ctrl_reg;
    logic [CFG_W-1:0]  cfg_reg [NUM_AN];
    logic [INT_W-1:0]  int_st_reg;
    logic [INT_W-1:0]  int_mask_reg;
    logic [31:0]       prdata_reg;
    logic              pready_reg;
    logic              pslverr_reg;
    logic              port_out_reg;
    logic              irq_reg;
    logic              warn_reg;
    logic [NUM_AN-1:0] arm_pulse_reg;
    logic [NUM_AN-1:0] seq_en_reg;
    logic [NUM_AN-1:0] trig_found_reg;
    logic [NUM_AN-1:0] time_tag_reg;
    logic [NUM_AN-1:0] state_tag_reg;
    logic [LVL_W-1:0]  lvl_reg [NUM_AN];
    arm_state_t        state_reg [NUM_AN];
    arm_state_t        state_next [NUM_AN];
    logic [NUM_AN-1:0] arm_event;
    logic [NUM_AN-1:0] trig_q;
    logic [NUM_AN-1:0] time_sel;
    logic              port_pulse;
    logic              src_pulse;
    logic              out_from;
    logic              setup_ph;
    logic              wr_acc;
    logic [31:0]       rd_word;
    logic [INT_W-1:0]  int_set;
    logic              warn_next;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] o);
        hit = (a == o);
    endfunction

    function automatic logic [CFG_W-1:0] clean_cfg(input logic [31:0] d);
        logic [CFG_W-1:0] c;
        c = d[CFG_W-1:0];
        // Undefined fourth tag code falls back to no tagging
        if (c[CFG_TAG_LSB +: 2] == 2'b11) begin
            c[CFG_TAG_LSB +: 2] = TAG_OFF;
        end
        clean_cfg = c;
    endfunction

    arm_edge_sync u_sync (
        .core_clk   (core_clk),
        .arst_n     (arst_n),
        .pin_in     (port_in),
        .rise_pulse (port_pulse)
    );

    // Bus handshake: one wait state per transfer
    assign setup_ph = psel & penable & ~pready_reg;
    assign wr_acc   = psel & penable & pready_reg & pwrite;

    always_comb begin
        rd_word = 32'h0000_0000;
        if (hit(paddr, OFS_CTRL)) begin
            rd_word[CTRL_W-1:0] = ctrl_reg;
        end else if (hit(paddr, OFS_CFG_A)) begin
            rd_word[CFG_W-1:0] = cfg_reg[0];
        end else if (hit(paddr, OFS_CFG_B)) begin
            rd_word[CFG_W-1:0] = cfg_reg[1];
        end else if (hit(paddr, OFS_STAT)) begin
            rd_word[STAT_ST_A +: 2] = state_reg[0];
            rd_word[STAT_ST_B +: 2] = state_reg[1];
            rd_word[STAT_PORT]      = port_out_reg;
            rd_word[STAT_WARN]      = warn_reg;
        end else if (hit(paddr, OFS_INT_ST)) begin
            rd_word[INT_W-1:0] = int_st_reg;
        end else if (hit(paddr, OFS_INT_MASK)) begin
            rd_word[INT_W-1:0] = int_mask_reg;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end else begin
            pready_reg  <= setup_ph;
            pslverr_reg <= setup_ph & ~(hit(paddr, OFS_CTRL) | hit(paddr, OFS_CFG_A) |
                           hit(paddr, OFS_CFG_B) | hit(paddr, OFS_STAT) |
                           hit(paddr, OFS_INT_ST) | hit(paddr, OFS_INT_MASK));
            if (setup_ph & ~pwrite) begin
                prdata_reg <= rd_word;
            end
        end
    end

    // Configuration registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_reg     <= CTRL_RST;
            cfg_reg[0]   <= CFG_RST;
            cfg_reg[1]   <= CFG_RST;
            int_mask_reg <= '0;
        end else if (wr_acc) begin
            if (hit(paddr, OFS_CTRL)) begin
                ctrl_reg <= pwdata[CTRL_W-1:0];
            end
            if (hit(paddr, OFS_CFG_A)) begin
                cfg_reg[0] <= clean_cfg(pwdata);
            end
            if (hit(paddr, OFS_CFG_B)) begin
                cfg_reg[1] <= clean_cfg(pwdata);
            end
            if (hit(paddr, OFS_INT_MASK)) begin
                int_mask_reg <= pwdata[INT_W-1:0];
            end
        end
    end

    // Run start or the synchronised arm edge
    assign src_pulse = ctrl_reg[CTRL_ARM_SRC] ? port_pulse : run_start;
    // Single analyzer setups always send from the first
    assign out_from = ctrl_reg[CTRL_DUAL] & ctrl_reg[CTRL_OUT_FROM];

    genvar g;
    generate
        for (g = 0; g < NUM_AN; g++) begin : g_an
            localparam int OTH = NUM_AN - 1 - g;

            // Other analyzer's found trigger may arm this one
            assign arm_event[g] = cfg_reg[g][CFG_FROM_OTH] ? trig_q[OTH] : src_pulse;
            // Triggers count only once armed
            assign trig_q[g] = (state_reg[g] == ST_ARMED) & trig_hit[g];
            assign time_sel[g] = cfg_reg[g][CFG_TIMING] |
                                 (cfg_reg[g][CFG_TAG_LSB +: 2] == TAG_TIME);

            always_comb begin
                state_next[g] = state_reg[g];
                case (state_reg[g])
                    ST_IDLE: begin
                        if (run_start) begin
                            state_next[g] = cfg_reg[g][CFG_WAIT] ? ST_WAIT : ST_ARMED;
                        end
                    end
                    ST_WAIT: begin
                        if (arm_event[g]) begin
                            state_next[g] = ST_ARMED;
                        end
                    end
                    ST_ARMED: begin
                        if (trig_hit[g]) begin
                            state_next[g] = ST_DONE;
                        end
                    end
                    ST_DONE: begin
                        state_next[g] = ST_DONE;
                    end
                    default: begin
                        state_next[g] = ST_IDLE;
                    end
                endcase
                if (run_stop) begin
                    state_next[g] = ST_IDLE;
                end
            end

            always_ff @(posedge core_clk or negedge arst_n) begin
                if (!arst_n) begin
                    state_reg[g]      <= ST_IDLE;
                    arm_pulse_reg[g]  <= 1'b0;
                    seq_en_reg[g]     <= 1'b0;
                    trig_found_reg[g] <= 1'b0;
                    lvl_reg[g]        <= '0;
                    time_tag_reg[g]   <= 1'b0;
                    state_tag_reg[g]  <= 1'b0;
                end else begin
                    state_reg[g]      <= state_next[g];
                    arm_pulse_reg[g]  <= (state_reg[g] == ST_WAIT) & arm_event[g] & ~run_stop;
                    seq_en_reg[g]     <= (state_next[g] == ST_ARMED);
                    trig_found_reg[g] <= trig_q[g];
                    lvl_reg[g]        <= cfg_reg[g][CFG_LVL_LSB +: LVL_W];
                    time_tag_reg[g]   <= time_sel[g];
                    state_tag_reg[g]  <= ~cfg_reg[g][CFG_TIMING] &
                                         (cfg_reg[g][CFG_TAG_LSB +: 2] == TAG_STATES);
                end
            end

            chk_wait_ignores: assert property (@(posedge core_clk) disable iff (!arst_n)
                (state_reg[g] == ST_WAIT) && trig_hit[g]
                |=> !trig_found_reg[g] && (state_reg[g] != ST_DONE))
                else $error("Trigger accepted before arm");
            chk_arm_moves: assert property (@(posedge core_clk) disable iff (!arst_n)
                (state_reg[g] == ST_WAIT) && arm_event[g] && !run_stop
                |=> (state_reg[g] == ST_ARMED) && arm_pulse_reg[g])
                else $error("Arm event not taken");
            chk_level_out: assert property (@(posedge core_clk) disable iff (!arst_n)
                arm_pulse_reg[g] && $stable(cfg_reg[g])
                |-> lvl_reg[g] == cfg_reg[g][CFG_LVL_LSB +: LVL_W])
                else $error("Arm level does not follow setting");
            chk_timing_tags: assert property (@(posedge core_clk) disable iff (!arst_n)
                cfg_reg[g][CFG_TIMING] |=> time_tag_reg[g] && !state_tag_reg[g])
                else $error("Timing analyzer lost time tags");
            // Per-analyzer sequencing and state tag checks
            chk_stop_idle: assert property (@(posedge core_clk) disable iff (!arst_n)
                run_stop |=> (state_reg[g] == ST_IDLE) && !seq_en_reg[g])
                else $error("Stop left analyzer busy");
            chk_found_pulse: assert property (@(posedge core_clk) disable iff (!arst_n)
                (state_reg[g] == ST_ARMED) && trig_hit[g] |=> trig_found_reg[g])
                else $error("Armed trigger not reported");
            chk_idle_armed: assert property (@(posedge core_clk) disable iff (!arst_n)
                (state_reg[g] == ST_IDLE) && run_start && !run_stop && !cfg_reg[g][CFG_WAIT]
                |=> (state_reg[g] == ST_ARMED))
                else $error("Immediate arm missed");
            chk_tag_states: assert property (@(posedge core_clk) disable iff (!arst_n)
                !cfg_reg[g][CFG_TIMING] && (cfg_reg[g][CFG_TAG_LSB +: 2] == TAG_STATES)
                |=> state_tag_reg[g] && !time_tag_reg[g])
                else $error("State count tagging lost");
        end
    endgenerate

    assign arm_level_a = lvl_reg[0];
    assign arm_level_b = lvl_reg[1];

    // Output stays high till next run start or output disable, so each trigger gives one clean edge
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            port_out_reg <= 1'b0;
        end else if (run_start | ~ctrl_reg[CTRL_OUT_EN]) begin
            port_out_reg <= 1'b0;
        end else if (trig_q[out_from]) begin
            port_out_reg <= 1'b1;
        end
    end

    // Warning only; the tag setting itself is never refused
    assign warn_next = (time_sel[0] & ~cfg_reg[0][CFG_TIMING]) |
                       (time_sel[1] & ~cfg_reg[1][CFG_TIMING]);

    assign int_set[INT_PORT]   = port_pulse;
    assign int_set[INT_TRIG_A] = trig_q[0];
    assign int_set[INT_TRIG_B] = trig_q[1];
    assign int_set[INT_WARN]   = warn_next & ~warn_reg;

    // Sticky status; a new event beats a same-cycle clear
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            int_st_reg <= '0;
            warn_reg   <= 1'b0;
            irq_reg    <= 1'b0;
        end else begin
            warn_reg <= warn_next;
            if (wr_acc && hit(paddr, OFS_INT_ST)) begin
                int_st_reg <= (int_st_reg & ~pwdata[INT_W-1:0]) | int_set;
            end else begin
                int_st_reg <= int_st_reg | int_set;
            end
            irq_reg <= |(int_st_reg & int_mask_reg);
        end
    end

    assign prdata       = prdata_reg;
    assign pready       = pready_reg;
    assign pslverr      = pslverr_reg;
    assign port_out     = port_out_reg;
    assign irq          = irq_reg;
    assign arm_pulse    = arm_pulse_reg;
    assign seq_enable   = seq_en_reg;
    assign trig_found   = trig_found_reg;
    assign time_tag_on  = time_tag_reg;
    assign state_tag_on = state_tag_reg;

    chk_port_rise: assert property (@(posedge core_clk) disable iff (!arst_n)
        ctrl_reg[CTRL_OUT_EN] && !run_start && trig_q[out_from] |=> port_out_reg)
        else $error("Port out missed trigger");
    chk_only_selected: assert property (@(posedge core_clk) disable iff (!arst_n)
        $rose(port_out_reg)
        |-> $past((ctrl_reg[CTRL_DUAL] && ctrl_reg[CTRL_OUT_FROM]) ? trig_q[1] : trig_q[0]))
        else $error("Port out from wrong analyzer");
    chk_port_edge: assert property (@(posedge core_clk) disable iff (!arst_n)
        ctrl_reg[CTRL_ARM_SRC] && src_pulse |=> !src_pulse)
        else $error("Arm input gave more than one pulse");
    chk_run_source: assert property (@(posedge core_clk) disable iff (!arst_n)
        !ctrl_reg[CTRL_ARM_SRC] && !cfg_reg[0][CFG_FROM_OTH] && run_start && !run_stop &&
        (state_reg[0] == ST_WAIT) |=> (state_reg[0] == ST_ARMED))
        else $error("Run arm source wrong");
    chk_warn_flag: assert property (@(posedge core_clk) disable iff (!arst_n)
        warn_next && !warn_reg |=> int_st_reg[INT_WARN] && warn_reg)
        else $error("Tag warning not raised");
    chk_tag_code: assert property (@(posedge core_clk) disable iff (!arst_n)
        cfg_reg[0][CFG_TAG_LSB +: 2] != 2'b11 && cfg_reg[1][CFG_TAG_LSB +: 2] != 2'b11)
        else $error("Illegal tag code stored");
    // Output enable and interrupt level checks
    chk_out_disabled: assert property (@(posedge core_clk) disable iff (!arst_n)
        !ctrl_reg[CTRL_OUT_EN] |=> !port_out_reg)
        else $error("Port out driven while disabled");
    chk_irq_level: assert property (@(posedge core_clk) disable iff (!arst_n)
        |(int_st_reg & int_mask_reg) |=> irq_reg)
        else $error("Unmasked event gave no interrupt");
endmodule
`default_nettype wire

/* verilog/xarm_pkg.sv */
// Package: register map, field layout and encodings of the arming crosslink
`default_nettype none
package xarm_pkg;
    localparam int ADDR_W = 8;
    localparam int LVL_W  = 4;
    localparam int INT_W  = 4;
    localparam int NUM_AN = 2;

    localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CFG_A    = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CFG_B    = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_STAT     = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_INT_ST   = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_INT_MASK = 8'h14;

    // Control word fields
    localparam int CTRL_ARM_SRC  = 0;
    localparam int CTRL_OUT_EN   = 1;
    localparam int CTRL_OUT_FROM = 2;
    localparam int CTRL_DUAL     = 3;
    localparam int CTRL_W        = 4;
    localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;

    // Per-analyzer configuration fields
    localparam int CFG_FROM_OTH = 0;
    localparam int CFG_WAIT     = 1;
    localparam int CFG_TIMING   = 2;
    localparam int CFG_LVL_LSB  = 4;
    localparam int CFG_TAG_LSB  = 8;
    localparam int CFG_W        = 10;
    localparam logic [CFG_W-1:0] CFG_RST = 10'h000;

    // Interrupt status bits
    localparam int INT_PORT   = 0;
    localparam int INT_TRIG_A = 1;
    localparam int INT_TRIG_B = 2;
    localparam int INT_WARN   = 3;

    // Status word fields
    localparam int STAT_ST_A  = 0;
    localparam int STAT_ST_B  = 2;
    localparam int STAT_PORT  = 4;
    localparam int STAT_WARN  = 5;

    typedef enum logic [1:0] {
        TAG_OFF    = 2'b00,
        TAG_TIME   = 2'b01,
        TAG_STATES = 2'b10
    } tag_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_WAIT  = 2'b01,
        ST_ARMED = 2'b10,
        ST_DONE  = 2'b11
    } arm_state_t;
endpackage
`default_nettype wire
